//--- verilog/anp_pkg.sv
package anp_pkg;
  // ---------------------------------------------------------------------------
  // Register map and field layout.
  // ---------------------------------------------------------------------------
  localparam logic [4:0]  PARTNER_NP_IDX   = 5'h08;   // Register index of the partner next page word.
  localparam logic [4:0]  EXPANSION_IDX    = 5'h06;   // Register index of the expansion register.
  localparam logic [15:0] PARTNER_NP_RESET = 16'h0000;
  localparam int          MORE_PAGES_BIT   = 15;
  localparam int          RESERVED_BIT     = 14;
  localparam int          PAGE_FORMAT_BIT  = 13;
  localparam int          COMPLY_ACK_BIT   = 12;
  localparam int          TOGGLE_BIT       = 11;
  localparam int          BASE_TOGGLE_BIT  = 11;     // Bit of the base word seeding the toggle.
  localparam int          CODE_MSB         = 10;
  localparam int          PAGE_RCVD_BIT    = 1;      // Page received flag position in the expansion register.
  localparam logic [15:0] RESERVED_MASK    = 16'h4000;
  localparam int          WORD_WIDTH       = 16;
  localparam int          CODE_WIDTH       = 11;

  // Exchange progress of the next page sequence.
  typedef enum logic [1:0] {
    ANP_IDLE,
    ANP_BASE_SEEN,
    ANP_PAGING,
    ANP_DONE
  } anp_state_t;
endpackage

//--- verilog/anp_page_flag.sv
`timescale 1ns/100ps
`default_nettype none
// Latching-high page received flag; a set in the clearing cycle wins.
module anp_page_flag (
  input  wire logic clk_sys_i,   // System clock.
  input  wire logic sys_rst_i,   // Synchronous reset, active high.
  input  wire logic set_i,       // New word stored this cycle.
  input  wire logic clr_i,       // Expansion register read this cycle.
  output logic      flag_o       // Latched flag.
);
  logic flag;
  logic next_flag;

  // Set beats clear so a page landing during the read is never lost.
  always_comb begin
    next_flag = flag;
    if (clr_i) begin
      next_flag = 1'b0;
    end
    if (set_i) begin
      next_flag = 1'b1;   // R11
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      flag <= 1'b0;
    end else begin
      flag <= next_flag;
    end
  end

  assign flag_o = flag;

  property p_flag_set;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      set_i |=> flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("Page flag not set after a store."); // R11

  property p_flag_clr;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (clr_i && !set_i) |=> !flag;
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("Page flag survived an expansion read."); // R11
endmodule
`default_nettype wire

//--- verilog/anp_partner_reg.sv
`timescale 1ns/100ps
`default_nettype none
// -----------------------------------------------------------------------------
// Partner next page word register
// -----------------------------------------------------------------------------
// Overview of operation
// R1: Read-only 16-bit register at index 8, holding partner next page word, resets zero.
// R2: Bit 15 shows whether more pages follow this one.
// R3: More pages allow next pages after base word only while partner supports them.
// R4: Bit 14 is reserved and always reads zero.
// R5: Management station should write default values into reserved bits.
// R6: Bit 13 shows message page versus unformatted page.
// R7: Bit 12 shows whether the sender can comply with the message.
// R8: Bit 11 toggle is the inverse of the previous next page toggle.
// R9: First next page toggle is inverse of base word bit 11.
// R10: Bits 10 to 0 hold message or unformatted code field.
// R11: Storing a new word sets a latching flag, cleared by reading expansion register.
// R12: Each valid next page word loads all fields at once.
module anp_partner_reg
  import anp_pkg::*;
(
  input  wire logic                         clk_sys_i,        // System clock, 40 MHz.
  input  wire logic                         sys_rst_i,        // Synchronous reset, active high.
  input  wire logic                         base_valid_i,     // Pulse: partner base word received.
  input  wire logic [anp_pkg::WORD_WIDTH-1:0] base_word_i,    // Partner base word.
  input  wire logic                         partner_np_able_i,// Partner supports next pages.
  input  wire logic                         page_valid_i,     // Pulse: partner next page word received.
  input  wire logic [anp_pkg::WORD_WIDTH-1:0] page_word_i,    // Partner next page word.
  input  wire logic                         rd_en_i,          // Management read strobe.
  input  wire logic [4:0]                   rd_idx_i,         // Management register index.
  input  wire logic                         wr_en_i,          // Management write strobe (ignored).
  output logic [anp_pkg::WORD_WIDTH-1:0]    rd_data_o,        // Read data, registered.
  output logic                              rd_hit_o,         // Registered: read hit this register.
  output logic                              page_rcvd_o,      // Latched page received flag.
  output logic                              np_permit_o,      // More next pages may follow.
  output logic                              toggle_err_o      // Last stored page broke toggle order.
);
  import anp_pkg::*;

  // ---------------------------------------------------------------------------
  // Page word storage.
  // ---------------------------------------------------------------------------
  logic [WORD_WIDTH-1:0] word;
  logic [WORD_WIDTH-1:0] next_word;
  logic                  exp_toggle;
  logic                  next_exp_toggle;
  logic                  tog_err;
  logic                  next_tog_err;
  anp_state_t            state;
  anp_state_t            next_state;
  logic                  store;

  // Only pages after a base word are taken; stray pages are dropped.
  // A base word in the same cycle wins, so a dropped page never raises the page flag.
  assign store = page_valid_i && !base_valid_i && (state == ANP_BASE_SEEN || state == ANP_PAGING);

  // Whole word loads in one cycle so a read never sees a mix of pages.
  always_comb begin
    next_word       = word;
    next_exp_toggle = exp_toggle;
    next_tog_err    = tog_err;
    next_state      = state;
    unique case (state)
      ANP_IDLE, ANP_DONE: begin
        if (base_valid_i) begin
          next_exp_toggle = ~base_word_i[BASE_TOGGLE_BIT];   // R9
          next_state      = (base_word_i[MORE_PAGES_BIT] && partner_np_able_i) ? ANP_BASE_SEEN : ANP_DONE; // R3
        end
      end
      ANP_BASE_SEEN, ANP_PAGING: begin
        if (base_valid_i) begin
          next_exp_toggle = ~base_word_i[BASE_TOGGLE_BIT];   // R9
          next_state      = (base_word_i[MORE_PAGES_BIT] && partner_np_able_i) ? ANP_BASE_SEEN : ANP_DONE;
        end else if (page_valid_i) begin
          next_word                 = page_word_i & ~RESERVED_MASK;       // R6 R7 R12
          next_tog_err              = page_word_i[TOGGLE_BIT] != exp_toggle; // R8
          next_exp_toggle           = ~page_word_i[TOGGLE_BIT];           // R8
          next_state                = (page_word_i[MORE_PAGES_BIT] && partner_np_able_i) ? ANP_PAGING : ANP_DONE; // R2 R3
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      word       <= PARTNER_NP_RESET;   // R1
      exp_toggle <= 1'b0;
      tog_err    <= 1'b0;
      state      <= ANP_IDLE;
    end else begin
      word       <= next_word;
      exp_toggle <= next_exp_toggle;
      tog_err    <= next_tog_err;
      state      <= next_state;
    end
  end

  // ---------------------------------------------------------------------------
  // Management read path.
  // ---------------------------------------------------------------------------
  logic [WORD_WIDTH-1:0] rdata;
  logic [WORD_WIDTH-1:0] next_rdata;
  logic                  hit;
  logic                  next_hit;
  logic                  exp_rd;
  logic                  pflag;

  assign exp_rd = rd_en_i && (rd_idx_i == EXPANSION_IDX);

  // Writes are ignored outright: the register is read-only, reserved stays zero.
  always_comb begin
    next_rdata = rdata;
    next_hit   = 1'b0;
    if (rd_en_i && rd_idx_i == PARTNER_NP_IDX) begin
      next_rdata = word & ~RESERVED_MASK;   // R1 R4 R10
      next_hit   = 1'b1;
    end else if (exp_rd) begin
      next_rdata                = '0;
      next_rdata[PAGE_RCVD_BIT] = pflag;    // R11
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      rdata <= '0;
      hit   <= 1'b0;
    end else begin
      rdata <= next_rdata;
      hit   <= next_hit;
    end
  end

  anp_page_flag u_flag (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .set_i     (store),
    .clr_i     (exp_rd),
    .flag_o    (pflag)
  );

  assign rd_data_o    = rdata;
  assign rd_hit_o     = hit;
  assign page_rcvd_o  = pflag;
  assign np_permit_o  = (state == ANP_BASE_SEEN) || (state == ANP_PAGING);
  assign toggle_err_o = tog_err;

  // ---------------------------------------------------------------------------
  // Checks.
  // ---------------------------------------------------------------------------
  property p_reserved_zero;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      !rdata[RESERVED_BIT];
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved bit read as one."); // R4

  property p_store_whole;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (store && !base_valid_i) |=> word == ($past(page_word_i) & ~RESERVED_MASK);
  endproperty
  a_store_whole: assert property (p_store_whole) else $error("Page word not stored whole."); // R12

  property p_read_word;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (rd_en_i && rd_idx_i == PARTNER_NP_IDX) |=> hit && rdata == ($past(word) & ~RESERVED_MASK);
  endproperty
  a_read_word: assert property (p_read_word) else $error("Read data differs from stored word."); // R10

  property p_permit;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (base_valid_i && !partner_np_able_i) |=> !np_permit_o;
  endproperty
  a_permit: assert property (p_permit) else $error("Next pages permitted without partner support."); // R3

  property p_last_page;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (store && !base_valid_i && !page_word_i[MORE_PAGES_BIT]) |=> !np_permit_o;
  endproperty
  a_last_page: assert property (p_last_page) else $error("Last page did not end paging."); // R2

  property p_first_toggle;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      base_valid_i |=> exp_toggle == !$past(base_word_i[BASE_TOGGLE_BIT]);
  endproperty
  a_first_toggle: assert property (p_first_toggle) else $error("First toggle not seeded from base."); // R9

  property p_toggle_check;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (store && !base_valid_i) |=> toggle_err_o == ($past(page_word_i[TOGGLE_BIT]) != $past(exp_toggle));
  endproperty
  a_toggle_check: assert property (p_toggle_check) else $error("Toggle order check wrong."); // R8

  property p_flag_follow;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      store |=> page_rcvd_o;
  endproperty
  a_flag_follow: assert property (p_flag_follow) else $error("Page flag missing after store."); // R11

  property p_ro;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (wr_en_i && !store && !base_valid_i) |=> $stable(word);
  endproperty
  a_ro: assert property (p_ro) else $error("Write altered the read-only word."); // R1

  // Reset is checked without a disable so that the cleared state itself is seen.
  property p_reset_clear;
    @(posedge clk_sys_i)
      sys_rst_i |=> (word == PARTNER_NP_RESET) && !page_rcvd_o && !toggle_err_o && !np_permit_o;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("State not cleared by reset."); // R1

  property p_hit_only_idx;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      !(rd_en_i && rd_idx_i == PARTNER_NP_IDX) |=> !hit;
  endproperty
  a_hit_only_idx: assert property (p_hit_only_idx) else $error("Read hit without a read of this register."); // R1

  property p_base_wins;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      base_valid_i |=> $stable(word) && !$rose(page_rcvd_o);
  endproperty
  a_base_wins: assert property (p_base_wins) else $error("Page taken in a base word cycle."); // R11 R12

  property p_stray_page;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (page_valid_i && !np_permit_o) |=> $stable(word) && !$rose(page_rcvd_o);
  endproperty
  a_stray_page: assert property (p_stray_page) else $error("Page stored while next pages were not permitted."); // R3

  property p_permit_rise;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (base_valid_i && base_word_i[MORE_PAGES_BIT] && partner_np_able_i) |=> np_permit_o;
  endproperty
  a_permit_rise: assert property (p_permit_rise) else $error("Next pages not permitted after a paging base."); // R3

  property p_exp_read;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      exp_rd |=> !hit && (rdata[PAGE_RCVD_BIT] == $past(pflag)) && $onehot0(rdata);
  endproperty
  a_exp_read: assert property (p_exp_read) else $error("Expansion read returned a wrong page flag."); // R11
endmodule
`default_nettype wire

//--- verif/anp_link_partner.sv
`timescale 1ns/100ps
`default_nettype none
// -----------------------------------------------------------------------------
// Remote link partner model
// -----------------------------------------------------------------------------
// Sends base and next page words as one-cycle strobes after a rising edge.
module anp_link_partner (
  input  wire logic        clk_sys_i,     // System clock.
  output logic             base_valid_o,  // Base word strobe.
  output logic [15:0]      base_word_o,   // Base word.
  output logic             np_able_o,     // Partner supports next pages.
  output logic             page_valid_o,  // Next page strobe.
  output logic [15:0]      page_word_o    // Next page word.
);
  logic toggle;  // Toggle carried by the next page to be sent.

  // Idle lines at time zero.
  initial begin
    base_valid_o = 1'b0;
    base_word_o  = 16'h0000;
    np_able_o    = 1'b0;
    page_valid_o = 1'b0;
    page_word_o  = 16'h0000;
    toggle       = 1'b0;
  end

  // The base word seeds the toggle of the first next page.
  task automatic send_base(input logic [15:0] w, input logic able);
    @(posedge clk_sys_i);
    base_valid_o <= 1'b1;
    base_word_o  <= w;
    np_able_o    <= able;
    toggle       = ~w[11];
    @(posedge clk_sys_i);
    base_valid_o <= 1'b0;
    base_word_o  <= ~w;  // Released lines must not keep the last value.
    #1;  // Return once the design has registered the strobe.
  endtask

  // All fields go out in one word; bad_tgl repeats the last toggle on purpose.
  task automatic send_page(input logic [15:0] w, input logic bad_tgl);
    logic sent;
    sent = toggle ^ bad_tgl;
    @(posedge clk_sys_i);
    page_valid_o <= 1'b1;
    page_word_o  <= {w[15:12], sent, w[10:0]};
    toggle       = ~sent;
    @(posedge clk_sys_i);
    page_valid_o <= 1'b0;
    page_word_o  <= ~{w[15:12], sent, w[10:0]};
    #1;  // Outputs are looked at only after they have settled.
  endtask
endmodule
`default_nettype wire

//--- verif/anp_partner_reg_test.sv
`timescale 1ns/100ps
`default_nettype none
module anp_partner_reg_test;
  import anp_pkg::*;
  logic        clk_sys_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        rd_en_i   = 1'b0;
  logic [4:0]  rd_idx_i  = 5'h00;
  logic        wr_en_i   = 1'b0;
  logic        base_valid, np_able, page_valid, hit;
  logic [15:0] base_word, page_word, data;
  logic [15:0] rd_data_o;
  logic        rd_hit_o, page_rcvd_o, np_permit_o, toggle_err_o;
  int          fails = 0;
  int          num_checks = 0;

  // ---------------------------------------------------------------------------
  // Clock, reset and instances
  // ---------------------------------------------------------------------------
  // A 25 ns period gives the 40 MHz system clock.
  always #12.5 clk_sys_i = ~clk_sys_i;

  anp_link_partner u_partner (.clk_sys_i(clk_sys_i), .base_valid_o(base_valid), .base_word_o(base_word),
    .np_able_o(np_able), .page_valid_o(page_valid), .page_word_o(page_word));

  anp_partner_reg u_dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .base_valid_i(base_valid),
    .base_word_i(base_word), .partner_np_able_i(np_able), .page_valid_i(page_valid),
    .page_word_i(page_word), .rd_en_i(rd_en_i), .rd_idx_i(rd_idx_i), .wr_en_i(wr_en_i),
    .rd_data_o(rd_data_o), .rd_hit_o(rd_hit_o), .page_rcvd_o(page_rcvd_o),
    .np_permit_o(np_permit_o), .toggle_err_o(toggle_err_o));

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  // Case equality so that an unknown never passes.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Single-bit results are compared at their own width so nothing is padded.
  task automatic chk_flag(input logic got, input logic exp, input string what);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  // The hit stands one cycle, so the answer is sampled just after the taking edge.
  task automatic rd(input logic [4:0] idx);
    @(posedge clk_sys_i);
    rd_en_i  <= 1'b1;
    rd_idx_i <= idx;
    @(posedge clk_sys_i);
    rd_en_i  <= 1'b0;
    #1;
    hit  = rd_hit_o;
    data = rd_data_o;
  endtask

  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset;
    rd(5'h08);
    chk_flag(hit, 1'b1, "hit idx 8");
    chk(data, PARTNER_NP_RESET, "reset word");
    chk_flag(page_rcvd_o, 1'b0, "reset page flag");
    chk_flag(np_permit_o, 1'b0, "reset permit");
    chk_flag(toggle_err_o, 1'b0, "reset toggle error");
    rd(5'h09);
    chk_flag(hit, 1'b0, "hit idx 9");
    $display("test reset done");
  endtask

  // Base 8800 seeds toggle 0; the reserved bit is sent set and must read zero.
  task automatic t_pages;
    u_partner.send_base(16'h8800, 1'b1);
    chk_flag(np_permit_o, 1'b1, "permit after base");
    u_partner.send_page(16'hf5a5, 1'b0);
    chk_flag(page_rcvd_o, 1'b1, "page flag page 1");
    chk_flag(toggle_err_o, 1'b0, "toggle error page 1");
    rd(5'h08);
    chk(data, 16'hb5a5, "page 1 word");
    u_partner.send_page(16'h0123, 1'b0);
    rd(5'h08);
    chk(data, 16'h0923, "page 2 word");
    chk_flag(np_permit_o, 1'b0, "permit after last");
    $display("test pages done");
  endtask

  // The first expansion read returns the flag and clears it.
  task automatic t_expansion;
    rd(EXPANSION_IDX);
    chk_flag(hit, 1'b0, "expansion no hit");
    chk(data, 16'h0002, "expansion set");
    rd(EXPANSION_IDX);
    chk_flag(page_rcvd_o, 1'b0, "expansion flag cleared");
    chk(data, 16'h0000, "expansion clear");
    $display("test expansion done");
  endtask

  task automatic t_write;
    @(posedge clk_sys_i);
    wr_en_i  <= 1'b1;
    rd_idx_i <= 5'h08;
    @(posedge clk_sys_i);
    wr_en_i <= 1'b0;
    rd(5'h08);
    chk(data, 16'h0923, "write ignored");
    $display("test write done");
  endtask

  // Without partner support no page may land.
  task automatic t_no_np;
    u_partner.send_base(16'h8000, 1'b0);
    chk_flag(np_permit_o, 1'b0, "no permit");
    u_partner.send_page(16'h3456, 1'b0);
    chk_flag(page_rcvd_o, 1'b0, "no flag for refused page");
    rd(5'h08);
    chk(data, 16'h0923, "page refused");
    $display("test no support done");
  endtask

  // A wrong toggle is flagged but the word is still stored.
  task automatic t_toggle;
    u_partner.send_base(16'h8000, 1'b1);
    u_partner.send_page(16'h2001, 1'b1);
    chk_flag(toggle_err_o, 1'b1, "toggle error");
    rd(5'h08);
    chk(data, 16'h2001, "bad toggle word");
    $display("test toggle done");
  endtask

  // A reset in mid-run must clear the stored word and every flag.
  task automatic t_mid_reset;
    @(posedge clk_sys_i);
    sys_rst_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    rd(PARTNER_NP_IDX);
    chk(data, PARTNER_NP_RESET, "word after reset");
    chk_flag(page_rcvd_o, 1'b0, "flag after reset");
    chk_flag(toggle_err_o, 1'b0, "toggle error after reset");
    chk_flag(np_permit_o, 1'b0, "permit after reset");
    $display("test mid reset done");
  endtask

  // Reset is held for three cycles before the first request.
  initial begin
    repeat (3) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    t_reset();
    t_pages();
    t_expansion();
    t_write();
    t_no_np();
    t_toggle();
    t_mid_reset();
    end_of_test();
  end

  // The tests take under 50 cycles; 1000 leaves ample margin.
  initial begin
    #25000;
    fails++;
    end_of_test();
  end
endmodule
`default_nettype wire
